// file: pkg/wdt_clear_pkg.sv
// constants and types for the watchdog clear logic
// How it works
// - single clear instruction zeroes counter and timeout flag at once, and the power-down flag unless an entry comes in that cycle
// - first pre-clear clears only when alternating with second, completing a pair
// - repeated first pre-clear without second changes nothing after the first
// - repeated second pre-clear without first has no clearing effect
// - completed second-then-first alternation zeroes counter, timeout flag and power-down flag unless an entry comes in the clearing cycle
package wdt_clear_pkg;
    localparam int unsigned CNT_W        = 8;
    localparam int unsigned PRE_W        = 8;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
    localparam logic [PRE_W-1:0] PRE_MAX = 8'hFF;
    localparam logic FLAG_RST            = 1'b0;

    typedef enum logic [2:0] {
        TRK_IDLE   = 3'b001,
        TRK_FIRST  = 3'b010,
        TRK_SECOND = 3'b100
    } trk_state_e;
endpackage : wdt_clear_pkg

// file: pkg/preclear_if.sv
// carrier between the watchdog controller and its pre-clear pair tracker
`timescale 1ns/1ps
interface preclear_if;
    logic first;
    logic second;
    logic pair_done;

    modport ctrl (output first, output second, input  pair_done);
    modport trk  (input  first, input  second, output pair_done);
endinterface : preclear_if

// file: core/preclear_tracker.sv
// alternation tracker for the two pre-clear instructions
`timescale 1ns/1ps
module preclear_tracker (
    input  wire logic   clk_i,
    input  wire logic   nrst_i,
    preclear_if.trk     pc
);
    wdt_clear_pkg::trk_state_e state;
    wdt_clear_pkg::trk_state_e next_state;
    logic                      next_done;

    // pair completes only on the opposite instruction; repeats hold state
    always_comb begin
        next_state = state;
        next_done  = 1'b0;
        case (state)
            wdt_clear_pkg::TRK_IDLE: begin
                if (pc.first) begin
                    next_state = wdt_clear_pkg::TRK_FIRST;
                end else if (pc.second) begin
                    next_state = wdt_clear_pkg::TRK_SECOND;
                end
            end
            wdt_clear_pkg::TRK_FIRST: begin
                if (pc.second) begin
                    next_done  = 1'b1;
                    next_state = wdt_clear_pkg::TRK_IDLE;
                end
                // repeated first stays put
            end
            wdt_clear_pkg::TRK_SECOND: begin
                if (pc.first) begin
                    next_done  = 1'b1;
                    next_state = wdt_clear_pkg::TRK_IDLE;
                end
                // repeated second stays put
            end
            default: begin
                next_state = wdt_clear_pkg::TRK_IDLE;
            end
        endcase
    end

    // done is a registered one-cycle pulse
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state        <= wdt_clear_pkg::TRK_IDLE;
            pc.pair_done <= 1'b0;
        end else begin
            state        <= next_state;
            pc.pair_done <= next_done;
        end
    end
endmodule : preclear_tracker

// file: core/wdt_clear_ctrl.sv
// watchdog counter, status flags and clear-instruction handling
`timescale 1ns/1ps
module wdt_clear_ctrl (
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    input  wire logic                        wdt_enable_i,
    input  wire logic                        clear_watchdog_single_i,
    input  wire logic                        watchdog_preclear_first_i,
    input  wire logic                        watchdog_preclear_second_i,
    input  wire logic                        power_down_entry_i,
    output logic [wdt_clear_pkg::CNT_W-1:0]  wdt_count_o,
    output logic                             timeout_flag_o,
    output logic                             power_down_flag_o,
    output logic                             wdt_reset_o,
    output logic                             wdt_cleared_o
);
    preclear_if pc ();

    logic [wdt_clear_pkg::PRE_W-1:0] prescale;
    logic [wdt_clear_pkg::PRE_W-1:0] next_prescale;
    logic [wdt_clear_pkg::CNT_W-1:0] next_count;
    logic                            next_timeout;
    logic                            next_power_down;
    logic                            next_wdt_reset;
    logic                            next_cleared;
    logic                            tick;
    logic                            overflow;
    logic                            clear_now;

    // one of the two pre-clear strobes reaches the tracker per cycle;
    // a simultaneous pair is not a legal decode and first takes it
    assign pc.first  = watchdog_preclear_first_i;
    assign pc.second = watchdog_preclear_second_i
                       & ~watchdog_preclear_first_i;

    preclear_tracker u_tracker (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .pc     (pc)
    );

    // pair clear lands one cycle after the completing instruction,
    // since the tracker registers its done pulse
    assign clear_now = clear_watchdog_single_i | pc.pair_done;

    // prescaler gives a one-cycle tick to the counter
    assign tick     = wdt_enable_i && (prescale == wdt_clear_pkg::PRE_MAX);
    assign overflow = tick && (wdt_count_o == wdt_clear_pkg::CNT_MAX);

    // counter and prescaler; a clear restarts both from zero
    always_comb begin
        next_prescale = prescale;
        next_count    = wdt_count_o;
        if (clear_now) begin
            next_prescale = wdt_clear_pkg::PRE_RST;
            next_count    = wdt_clear_pkg::CNT_RST;
        end else if (wdt_enable_i) begin
            next_prescale = prescale + 1'b1;
            if (tick) begin
                next_count = wdt_count_o + 1'b1; // wraps after overflow
            end
        end
    end

    // flags: a power-down entry in the clearing cycle wins over the clear,
    // but an overflow in that cycle is lost and the clear wins
    always_comb begin
        next_timeout    = timeout_flag_o;
        next_power_down = power_down_flag_o;
        if (clear_now) begin
            next_timeout    = 1'b0;
            next_power_down = 1'b0;
        end
        if (overflow && !clear_now) begin
            next_timeout = 1'b1;
        end
        if (power_down_entry_i) begin
            next_power_down = 1'b1;
        end
        next_wdt_reset = overflow && !clear_now;
        next_cleared   = clear_now;
    end

    // registers only; all outputs come from here
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prescale          <= wdt_clear_pkg::PRE_RST;
            wdt_count_o       <= wdt_clear_pkg::CNT_RST;
            timeout_flag_o    <= wdt_clear_pkg::FLAG_RST;
            power_down_flag_o <= wdt_clear_pkg::FLAG_RST;
            wdt_reset_o       <= 1'b0;
            wdt_cleared_o     <= 1'b0;
        end else begin
            prescale          <= next_prescale;
            wdt_count_o       <= next_count;
            timeout_flag_o    <= next_timeout;
            power_down_flag_o <= next_power_down;
            wdt_reset_o       <= next_wdt_reset;
            wdt_cleared_o     <= next_cleared;
        end
    end
endmodule : wdt_clear_ctrl

// file: sim/wdt_clear_properties.sv
// checker for the watchdog clear logic and its bind
`timescale 1ns/1ps
module wdt_clear_properties (
    input wire logic                           clk_i,
    input wire logic                           nrst_i,
    input wire logic                           clear_watchdog_single_i,
    input wire logic                           watchdog_preclear_first_i,
    input wire logic                           watchdog_preclear_second_i,
    input wire logic                           power_down_entry_i,
    input wire logic [wdt_clear_pkg::CNT_W-1:0] wdt_count_o,
    input wire logic                           timeout_flag_o,
    input wire logic                           power_down_flag_o,
    input wire logic                           wdt_cleared_o
);
    wire c = clear_watchdog_single_i;
    wire f = watchdog_preclear_first_i;
    wire s = watchdog_preclear_second_i;
    logic [1:0] st;
    logic [1:0] next_st;
    // own copy of the pair tracker: 0 idle, 1 first seen, 2 second seen
    wire pair = (f && st == 2'h2) || (s && !f && st == 2'h1);
    always_comb begin
        next_st = st;
        if (f) next_st = (st == 2'h2) ? 2'h0 : 2'h1;
        else if (s) next_st = (st == 2'h1) ? 2'h0 : 2'h2;
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) st <= 2'h0;
        else st <= next_st;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    chk_single_clears: assert property (c && !power_down_entry_i |=>
        wdt_cleared_o && wdt_count_o == 8'h00 && !timeout_flag_o
        && !power_down_flag_o) else $error("single clear missed");
    chk_first_completes: assert property (f && pair |->
        ##2 wdt_cleared_o && wdt_count_o == 8'h00) else $error("pair missed");
    chk_second_completes: assert property (s && !f && pair
        ##1 !power_down_entry_i |=> wdt_cleared_o && !timeout_flag_o
        && !power_down_flag_o) else $error("pair clear incomplete");
    chk_first_repeat: assert property (f && !pair ##1 !c
        |=> !wdt_cleared_o) else $error("lone first cleared");
    chk_second_repeat: assert property (s && !f && !pair ##1 !c
        |=> !wdt_cleared_o) else $error("lone second cleared");
    chk_pair_rearm: assert property (pair ##1 (f || s) ##1 !c
        |=> !wdt_cleared_o) else $error("tracker not idle");
    cover property (f && pair);
    cover property (s && !f && pair);
    cover property (timeout_flag_o);
endmodule : wdt_clear_properties
bind wdt_clear_ctrl wdt_clear_properties u_wdt_clear_properties (.*);

// file: sim/test_wdt_clear_ctrl.sv
// random instruction test of the watchdog clear logic
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module test_wdt_clear_ctrl;
    logic clk_i = 1'b0, nrst_i = 1'b0, c = 1'b0, f = 1'b0, s = 1'b0;
    logic pd = 1'b0;
    logic [wdt_clear_pkg::CNT_W-1:0] cnt;
    logic tof, pdn, clr, rst;
    logic pd_seen = 1'b0;
    int   rst_cnt = 0;
    int error_cnt = 0, checks_done = 0, cyc = 0, st = 0, got, q[$];
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    wdt_clear_ctrl u_wdt_clear_ctrl (.clk_i(clk_i), .nrst_i(nrst_i),
        .wdt_enable_i(1'b1), .clear_watchdog_single_i(c),
        .watchdog_preclear_first_i(f), .watchdog_preclear_second_i(s),
        .power_down_entry_i(pd), .wdt_count_o(cnt), .timeout_flag_o(tof),
        .power_down_flag_o(pdn), .wdt_reset_o(rst), .wdt_cleared_o(clr));
    // entry pulse the design sampled at the last edge
    always @(posedge clk_i) pd_seen <= pd;
    // power-down flag: entry sets it, and wins over a clear in that cycle
    always @(negedge clk_i) if (nrst_i && (clr === 1'b1 || pd_seen)) begin
        `CHK(pdn, pd_seen)
    end
    // overflow request: counter wrapped and timeout flag raised
    always @(negedge clk_i) if (nrst_i && rst === 1'b1) begin
        rst_cnt++;
        `CHK(tof, 1'b1)
        `CHK(cnt, 8'h00)
    end
    task automatic stop_test;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // a single clear shows two edges on, a pair three (late tracker)
    task automatic note(int t);
        if (q.size() == 0 || q[$] != t) q.push_back(t);
    endtask : note
    // r: 0 single, 1 2 5 first (5 both), 3 4 second, else idle
    task automatic step(int r);
        c <= (r == 0);
        f <= (r inside {1, 2, 5});
        s <= (r inside {3, 4, 5});
        pd <= ($urandom % 8 == 0);
        if (r == 0) note(cyc + 2);
        if (r inside {1, 2, 5}) begin
            if (st == 2) note(cyc + 3);
            st = (st == 2) ? 0 : 1;
        end else if (r inside {3, 4}) begin
            if (st == 1) note(cyc + 3);
            st = (st == 1) ? 0 : 2;
        end
    endtask : step
    // each clear pulse takes the oldest note
    always @(negedge clk_i) if (nrst_i && clr === 1'b1) begin
        got = (q.size() > 0) ? q.pop_front() : -1;
        `CHK(got, cyc)
        `CHK(cnt, 8'h00)
        `CHK(tof, 1'b0)
    end
    // timeout phase needs 65536 idle cycles, so allow well beyond it
    initial begin
        #(80000 * 100);
        error_cnt++;
        stop_test();
    end
    initial begin
        void'($urandom(84));
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3000) begin @(posedge clk_i); step($urandom % 8); end
        repeat (66000) begin @(posedge clk_i); step(7); end
        @(negedge clk_i);
        `CHK(tof, 1'b1)
        `CHK(rst_cnt, 1)
        @(posedge clk_i);
        step(0);
        repeat (6) begin @(posedge clk_i); step(7); end
        @(negedge clk_i);
        `CHK(q.size(), 0)
        stop_test();
    end
endmodule : test_wdt_clear_ctrl
